// [hw/odc_defines.svh]
// Purpose: offsets, field positions, reset values and write masks for the output driver control
// Assumes: 16-bit registers addressed by index over the device's own write port
// Notes: definitions only
`ifndef ODC_DEFINES_SVH
`define ODC_DEFINES_SVH
`define ODC_ADDR_HB_MODE 4'h0 // half-bridge and mode control
`define ODC_ADDR_HS_MIRROR 4'h1 // high-side and mirror control
`define ODC_RST_HB_MODE 16'h0000
`define ODC_RST_HS_MIRROR 16'h0000
`define ODC_MASK_HB_MODE 16'hFC31 // writable bits of the first register
`define ODC_MASK_HS_MIRROR 16'hFFFE // writable bits of the second register
`define ODC_BIT_MODE 0
`define ODC_BIT_HB1_HI 15
`define ODC_BIT_HB2_HI 13
`define ODC_BIT_HB3_HI 11
`define ODC_BIT_HB4_HI 5
`define ODC_BIT_OUT5_HI 15
`define ODC_BIT_OUT6_HI 13
`define ODC_BIT_OUT7 11
`define ODC_BIT_OUT8 10
`define ODC_BIT_OUT9 9
`define ODC_BIT_FB_PD 8
`define ODC_BIT_REF_HI 7
`define ODC_BIT_REF_LO 2
`define ODC_BIT_MIRROR_EN 1
`define ODC_REF_CLAMP 6'h08 // highest code whose level, one volt plus code steps, stays under 1.2 V
`define ODC_REF_FULL 6'h3F
`endif

// [hw/odc_hb_decode.sv]
// Purpose: one half-bridge select decode with pwm gating
// Assumes: pwm level already synchronised
// Notes: combinational, registered by the caller
`timescale 1ns/1ps
module odc_hb_decode (
   input wire logic hi_sel,
   input wire logic lo_sel,
   input wire logic pwm_en,
   input wire logic pwm_lvl,
   output odc_pkg::odc_hb_s drv
);
   logic gate; // pwm permits conduction
   // decode select pair, never both sides on
   always_comb begin
      gate = !pwm_en || pwm_lvl;
      drv.hi_on = hi_sel && !lo_sel && gate;
      drv.lo_on = lo_sel && !hi_sel && gate;
   end
endmodule : odc_hb_decode

// [hw/odc_pkg.sv]
// Purpose: types shared by the output driver control files
// Assumes: odc_defines.svh carries the numbers
// Notes: half-bridge and lamp output drive state bundles
package odc_pkg;
   // decoded state of one half-bridge
   typedef struct packed {
      logic hi_on; // high side conducting
      logic lo_on; // low side conducting
   } odc_hb_s;
   // decoded state of one lamp output
   typedef struct packed {
      logic on; // conducting
      logic bulb; // high-current mode
   } odc_hs_s;
endpackage : odc_pkg

// [hw/odc_regs.sv]
// Purpose: two control registers and the output drive decode
// Assumes: the serial port has parsed frames into wr_en, wr_addr, wr_data
// Notes:
`timescale 1ns/1ps
`include "odc_defines.svh"
module odc_regs #(
   parameter int ADDR_W = 4 // register index width
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en, // one-cycle write strobe
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic [3:0] hb_pwm_en, // half-bridge 1..4 pwm enables
   input wire logic [4:0] hs_pwm_en, // outputs 5..9 pwm enables
   input wire logic fb_pwm_en, // pull-down pwm enable
   input wire logic internal_pulse_unit_enable,
   input wire logic internal_pulse, // internal generator level
   input wire logic full_scale_select,
   input wire logic pulse_input_a, // pin
   input wire logic pulse_input_b, // pin
   output logic [15:0] rd_data,
   output logic active,
   output odc_pkg::odc_hb_s [3:0] hb_drv,
   output odc_pkg::odc_hs_s [4:0] hs_drv,
   output logic feedback_pulldown_on,
   output logic pass_transistor_drive,
   output logic [5:0] ref_code
);
   logic [15:0] hbm_r, hbm_nxt; // half-bridge and mode register
   logic [15:0] hsm_r, hsm_nxt; // high-side and mirror register
   logic [2:0] pa_r, pb_r; // pin synchronisers
   logic [2:0] pa_nxt, pb_nxt;
   logic pa_lvl_r, pb_lvl_r, pa_lvl_nxt, pb_lvl_nxt; // filtered levels
   odc_pkg::odc_hb_s [3:0] hb_dec; // decoded half-bridges
   odc_pkg::odc_hb_s [3:0] hb_nxt;
   odc_pkg::odc_hs_s [4:0] hs_nxt;
   logic [15:0] rd_nxt;
   logic act_nxt, fb_nxt, pt_nxt;
   logic [5:0] ref_nxt;
   logic [3:0] hb_hi, hb_lo; // select bits per half-bridge
   logic [4:0] hs_en, hs_gate;
   logic [4:0] hs_src; // pwm source level per lamp output

   // gather select pairs
   assign hb_hi = {hbm_r[`ODC_BIT_HB4_HI], hbm_r[`ODC_BIT_HB3_HI],
                   hbm_r[`ODC_BIT_HB2_HI], hbm_r[`ODC_BIT_HB1_HI]};
   assign hb_lo = {hbm_r[`ODC_BIT_HB4_HI-1], hbm_r[`ODC_BIT_HB3_HI-1],
                   hbm_r[`ODC_BIT_HB2_HI-1], hbm_r[`ODC_BIT_HB1_HI-1]};

   // one decoder per half-bridge, all on the first pulse input
   for (genvar i = 0; i < 4; i++) begin : g_hb
      odc_hb_decode u_dec (
         .hi_sel(hb_hi[i]),
         .lo_sel(hb_lo[i]),
         .pwm_en(hb_pwm_en[i]),
         .pwm_lvl(pa_lvl_r),
         .drv(hb_dec[i])
      );
   end

   // pin synchronisers: a change counts when stages two and three agree
   always_comb begin
      pa_nxt = {pa_r[1:0], pulse_input_a};
      pb_nxt = {pb_r[1:0], pulse_input_b};
      pa_lvl_nxt = (pa_r[2] == pa_r[1]) ? pa_r[2] : pa_lvl_r;
      pb_lvl_nxt = (pb_r[2] == pb_r[1]) ? pb_r[2] : pb_lvl_r;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pa_r <= 3'h0;
         pb_r <= 3'h0;
         pa_lvl_r <= 1'b0;
         pb_lvl_r <= 1'b0;
      end else begin
         pa_r <= pa_nxt;
         pb_r <= pb_nxt;
         pa_lvl_r <= pa_lvl_nxt;
         pb_lvl_r <= pb_lvl_nxt;
      end
   end

   // register writes and standby clearing
   always_comb begin
      hbm_nxt = hbm_r;
      hsm_nxt = hsm_r;
      if (wr_en && wr_addr == `ODC_ADDR_HB_MODE) begin
         hbm_nxt = wr_data & `ODC_MASK_HB_MODE;
      end else if (wr_en && wr_addr == `ODC_ADDR_HS_MIRROR) begin
         hsm_nxt = wr_data & `ODC_MASK_HS_MIRROR;
      end
      // standby: everything but a fresh mode write is wiped
      if (!hbm_nxt[`ODC_BIT_MODE]) begin
         hbm_nxt = `ODC_RST_HB_MODE;
         hsm_nxt = `ODC_RST_HS_MIRROR;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         hbm_r <= `ODC_RST_HB_MODE;
         hsm_r <= `ODC_RST_HS_MIRROR;
      end else begin
         hbm_r <= hbm_nxt;
         hsm_r <= hsm_nxt;
      end
   end

   // lamp output enables and pwm sources
   always_comb begin
      hs_en[0] = hsm_r[`ODC_BIT_OUT5_HI] ^ hsm_r[`ODC_BIT_OUT5_HI-1];
      hs_en[1] = hsm_r[`ODC_BIT_OUT6_HI] ^ hsm_r[`ODC_BIT_OUT6_HI-1];
      hs_en[2] = hsm_r[`ODC_BIT_OUT7];
      hs_en[3] = hsm_r[`ODC_BIT_OUT8] || hsm_r[`ODC_BIT_MIRROR_EN];
      hs_en[4] = hsm_r[`ODC_BIT_OUT9];
      // 6 and 8 on input b, the rest on input a; internal unit ors in for 5..8
      hs_src = {pa_lvl_r, pb_lvl_r, pa_lvl_r, pb_lvl_r, pa_lvl_r};
      hs_src[3:0] = hs_src[3:0] | {4{internal_pulse_unit_enable && internal_pulse}};
      hs_gate = ~hs_pwm_en | hs_src;
   end

   // next output values, all off outside active mode
   always_comb begin
      act_nxt = hbm_r[`ODC_BIT_MODE];
      hb_nxt = hb_dec;
      hs_nxt = '0;
      for (int k = 0; k < 5; k++) begin
         hs_nxt[k].on = act_nxt && hs_en[k] && (hs_gate[k] || (k == 3 &&
                        hsm_r[`ODC_BIT_MIRROR_EN]));
      end
      hs_nxt[0].bulb = hsm_r[`ODC_BIT_OUT5_HI] && !hsm_r[`ODC_BIT_OUT5_HI-1];
      hs_nxt[1].bulb = hsm_r[`ODC_BIT_OUT6_HI] && !hsm_r[`ODC_BIT_OUT6_HI-1];
      ref_nxt = hsm_r[`ODC_BIT_REF_HI:`ODC_BIT_REF_LO];
      if (!full_scale_select && ref_nxt > `ODC_REF_CLAMP) begin
         ref_nxt = `ODC_REF_CLAMP;
      end
      fb_nxt = act_nxt && hsm_r[`ODC_BIT_FB_PD] &&
               hsm_r[`ODC_BIT_REF_HI:`ODC_BIT_REF_LO] == 6'h00 &&
               (!fb_pwm_en || pa_lvl_r);
      pt_nxt = act_nxt && hsm_r[`ODC_BIT_MIRROR_EN];
      if (!act_nxt) begin
         hb_nxt = '0;
      end
      // read mux, unmapped index reads zero
      unique case (rd_addr)
         `ODC_ADDR_HB_MODE: rd_nxt = hbm_r;
         `ODC_ADDR_HS_MIRROR: rd_nxt = hsm_r;
         default: rd_nxt = 16'h0000;
      endcase
   end

   // output registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         active <= 1'b0;
         hb_drv <= '0;
         hs_drv <= '0;
         feedback_pulldown_on <= 1'b0;
         pass_transistor_drive <= 1'b0;
         ref_code <= 6'h00;
         rd_data <= 16'h0000;
      end else begin
         active <= act_nxt;
         hb_drv <= hb_nxt;
         hs_drv <= hs_nxt;
         feedback_pulldown_on <= fb_nxt;
         pass_transistor_drive <= pt_nxt;
         ref_code <= ref_nxt;
         rd_data <= rd_nxt;
      end
   end
endmodule : odc_regs

// [sim/odc_host.sv]
// Purpose: host master issuing register writes
// Assumes: one-cycle write strobe, one idle cycle between writes
// Notes: waits the settling span before reactivating
`timescale 1ns/1ps
module odc_host #(
   parameter int SETTLE = 20 // standby settling span in cycles
) (
   input wire logic clk,
   output logic wr_en,
   output logic [3:0] wr_addr,
   output logic [15:0] wr_data
);
   int cyc = 0; // free cycle count
   int stby_at = -1000; // cycle of last standby write
   initial begin
      wr_en = 1'b0;
      wr_addr = 4'h0;
      wr_data = 16'h0000;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic write(input logic [3:0] a, input logic [15:0] d);
      // hold off reactivation until settled
      while (a == 4'h0 && d[0] && cyc - stby_at < SETTLE) @(posedge clk);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      if (a == 4'h0 && !d[0]) stby_at = cyc;
   endtask : write
endmodule : odc_host

// [sim/odc_regs_props.sv]
// Purpose: port checks for the output driver control registers
// Assumes: outputs follow the stored registers by one edge
// Notes: bound into every odc_regs
`timescale 1ns/1ps
module odc_regs_props #(
   parameter int ADDR_W = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic [3:0] hb_pwm_en,
   input wire logic pulse_input_a,
   input wire logic full_scale_select,
   input wire logic [15:0] rd_data,
   input wire logic active,
   input wire odc_pkg::odc_hb_s [3:0] hb_drv,
   input wire odc_pkg::odc_hs_s [4:0] hs_drv,
   input wire logic feedback_pulldown_on,
   input wire logic pass_transistor_drive,
   input wire logic [5:0] ref_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // mode write seen at output two edges later
   a_mode_sets_on: assert property (wr_en && wr_addr == 4'h0 && wr_data[0] ##1
      !(wr_en && wr_addr == 4'h0) |=> active) else $error("mode write ignored");
   a_mode_clears_all: assert property (wr_en && wr_addr == 4'h0 && !wr_data[0] |=> ##1
      (!active && hb_drv == '0 && hs_drv == '0 && !pass_transistor_drive)) else $error("no standby");
   a_hb_one_side: assert property (((8'(hb_drv) >> 1) & 8'(hb_drv) & 8'h55) == 8'h00)
      else $error("both sides on");
   a_hb_pwm_gate: assert property ((hb_pwm_en[0] && !pulse_input_a) [*7] |->
      hb_drv[0] == 2'b00) else $error("half-bridge ignores pulse");
   a_unmapped_zero: assert property (rd_addr > 4'h1 |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   a_pd_zero_code: assert property (feedback_pulldown_on |-> ref_code == 6'h00)
      else $error("pull-down with code");
   a_ref_clamp: assert property (!full_scale_select |=> ref_code <= 6'h08)
      else $error("code above clamp");
   a_mirror_out8: assert property (pass_transistor_drive |-> hs_drv[3].on)
      else $error("out8 not forced");
   c_active: cover property ($rose(active));
   c_pulldown: cover property (feedback_pulldown_on);
   c_mirror: cover property (pass_transistor_drive && hs_drv[3].on);
endmodule : odc_regs_props
bind odc_regs odc_regs_props #(.ADDR_W(ADDR_W)) i_odc_regs_props (.clk, .nrst, .wr_en,
   .wr_addr, .wr_data, .rd_addr, .hb_pwm_en, .pulse_input_a, .full_scale_select, .rd_data,
   .active, .hb_drv, .hs_drv, .feedback_pulldown_on, .pass_transistor_drive, .ref_code);

// [sim/output_driver_control_regs_bench.sv]
// Purpose: register and drive tests for odc_regs
// Assumes: host model performs all writes
// Notes: pulse pins changed at rising edges
`timescale 1ns/1ps
module output_driver_control_regs_bench;
   logic clk, nrst, wr_en, fb_pwm_en, fss, pa, pb, active, pd, pass, ipe, ip;
   logic [3:0] wr_addr, rd_addr, hb_pwm_en;
   logic [15:0] wr_data, rd_data;
   logic [4:0] hs_pwm_en;
   logic [5:0] ref_code;
   odc_pkg::odc_hb_s [3:0] hb_drv;
   odc_pkg::odc_hs_s [4:0] hs_drv;
   int err_count = 0;
   int cmp_count = 0;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   odc_host i_odc_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   odc_regs i_odc_regs (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .hb_pwm_en(hb_pwm_en), .hs_pwm_en(hs_pwm_en),
      .fb_pwm_en(fb_pwm_en), .internal_pulse_unit_enable(ipe), .internal_pulse(ip),
      .full_scale_select(fss), .pulse_input_a(pa), .pulse_input_b(pb), .rd_data(rd_data),
      .active(active), .hb_drv(hb_drv), .hs_drv(hs_drv), .feedback_pulldown_on(pd),
      .pass_transistor_drive(pass), .ref_code(ref_code));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // read through the registered read port
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd_addr <= a;
      @(posedge clk);
      #1 chk("rd_data", rd_data, e);
   endtask : rd
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask : settle
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
   initial begin
      {nrst, rd_addr, hb_pwm_en, hs_pwm_en, fb_pwm_en, fss, pa, pb, ipe, ip} = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(4'h0, 16'h0000);
      rd(4'h2, 16'h0000);
      $display("test reset done");
      i_odc_host.write(4'h0, 16'hFFFF);
      settle();
      rd(4'h0, 16'hFC31);
      chk("active", 16'(active), 16'h0001);
      chk("hb_drv", 16'(hb_drv), 16'h0000);
      i_odc_host.write(4'h0, 16'h9811);
      settle();
      chk("hb_drv", 16'(hb_drv), 16'h0066);
      @(posedge clk);
      hb_pwm_en <= 4'h1;
      pb <= 1'b1;
      settle();
      chk("hb_drv", 16'(hb_drv), 16'h0064);
      @(posedge clk);
      pa <= 1'b1;
      settle();
      chk("hb_drv", 16'(hb_drv), 16'h0066);
      $display("test half-bridge done");
      i_odc_host.write(4'h1, 16'hFFFF);
      settle();
      rd(4'h1, 16'hFFFE);
      chk("hs_drv", 16'(hs_drv), 16'h02A0);
      chk("ref_code", 16'(ref_code), 16'h0008);
      chk("pulldown", 16'(pd), 16'h0000);
      @(posedge clk);
      fss <= 1'b1;
      settle();
      chk("ref_code", 16'(ref_code), 16'h003F);
      i_odc_host.write(4'h1, 16'h6102);
      settle();
      chk("hs_drv", 16'(hs_drv), 16'h008E);
      chk("pass", 16'(pass), 16'h0001);
      chk("pulldown", 16'(pd), 16'h0001);
      // gate outputs 5, 6 and 8 and the pull-down, then swap the pin levels
      @(posedge clk);
      hs_pwm_en <= 5'h0B;
      fb_pwm_en <= 1'b1;
      {pa, pb} <= 2'b01;
      settle();
      chk("out5_on", 16'(hs_drv[0].on), 16'h0000);
      chk("out6_on", 16'(hs_drv[1].on), 16'h0001);
      chk("pulldown", 16'(pd), 16'h0000);
      @(posedge clk);
      {pa, pb} <= 2'b10;
      settle();
      chk("out5_on", 16'(hs_drv[0].on), 16'h0001);
      chk("out6_on", 16'(hs_drv[1].on), 16'h0000);
      chk("out8_on", 16'(hs_drv[3].on), 16'h0001);
      chk("pulldown", 16'(pd), 16'h0001);
      // internal generator as the pulse source of output 5
      @(posedge clk);
      {pa, ipe, ip} <= 3'b011;
      settle();
      chk("out5_on", 16'(hs_drv[0].on), 16'h0001);
      @(posedge clk);
      ip <= 1'b0;
      settle();
      chk("out5_on", 16'(hs_drv[0].on), 16'h0000);
      $display("test high-side done");
      i_odc_host.write(4'h0, 16'h0000);
      settle();
      chk("active", 16'(active), 16'h0000);
      chk("hs_drv", 16'(hs_drv), 16'h0000);
      rd(4'h1, 16'h0000);
      i_odc_host.write(4'h0, 16'h0001);
      settle();
      chk("active", 16'(active), 16'h0001);
      $display("test standby done");
      tally_and_finish();
   end
endmodule : output_driver_control_regs_bench
